/* File: tcx_pkg.sv */
// Constants, codes and crosspoint layout for the test code cross-connect controller.
// Assumes a single 20 MHz clock domain and no register bus.
package tcx_pkg;

	// ==========================================================
	// Network dimensions
	localparam int NUM_LEADS = 28;
	localparam int NUM_FUNCS = 15;
	localparam int LEAD_W = 5;
	localparam int FUNC_W = 4;
	localparam int CODE_W = 8;
	typedef logic [NUM_LEADS*NUM_FUNCS-1:0] tcx_net_t;

	// Function indices (function code minus one, code 01 z=1 at index 14).
	localparam logic [FUNC_W-1:0] F_SEND_PRBS = 4'h0;
	localparam logic [FUNC_W-1:0] F_RECV_BUF = 4'h1;
	localparam logic [FUNC_W-1:0] F_CTR_A = 4'h2;
	localparam logic [FUNC_W-1:0] F_CTR_B = 4'h3;
	localparam logic [FUNC_W-1:0] F_IND1 = 4'h4;
	localparam logic [FUNC_W-1:0] F_IND2 = 4'h5;
	localparam logic [FUNC_W-1:0] F_SW1 = 4'h8;
	localparam logic [FUNC_W-1:0] F_SW2 = 4'h9;
	localparam logic [FUNC_W-1:0] F_SW3 = 4'ha;
	localparam logic [FUNC_W-1:0] F_CLK_T = 4'hc;
	localparam logic [FUNC_W-1:0] F_CLK_R = 4'hd;
	localparam logic [FUNC_W-1:0] F_SEND_BUF = 4'he;

	// Lead indices (lead code minus one; 22, 23, 27 are the clock leads).
	localparam logic [LEAD_W-1:0] L_SD = 5'h00;
	localparam logic [LEAD_W-1:0] L_RD = 5'h01;
	localparam logic [LEAD_W-1:0] L_SCR = 5'h02;
	localparam logic [LEAD_W-1:0] L_SCT = 5'h03;
	localparam logic [LEAD_W-1:0] L_RS = 5'h04;
	localparam logic [LEAD_W-1:0] L_CS = 5'h05;
	localparam logic [LEAD_W-1:0] L_DSR = 5'h06;
	localparam logic [LEAD_W-1:0] L_RLSD = 5'h07;
	localparam logic [LEAD_W-1:0] L_SRS9 = 5'h08;
	localparam logic [LEAD_W-1:0] L_SRLSD = 5'h09;
	localparam logic [LEAD_W-1:0] L_SRS15 = 5'h0e;
	localparam logic [LEAD_W-1:0] L_DTR = 5'h0f;
	localparam logic [LEAD_W-1:0] L_SQD = 5'h10;
	localparam logic [LEAD_W-1:0] L_RI = 5'h11;
	localparam logic [LEAD_W-1:0] L_ASYNC_CLK = 5'h15;
	localparam logic [LEAD_W-1:0] L_DEV_TCLK = 5'h16;
	localparam logic [LEAD_W-1:0] L_CSU_CLK = 5'h1a;

	// Data set classes.
	typedef enum logic [1:0]
	{
		DS_SYNC = 2'b00,
		DS_ASYNC = 2'b01,
		DS_CSU = 2'b10,
		DS_NONE = 2'b11
	} tcx_class_e;

	// Test codes that touch the network.
	localparam logic [CODE_W-1:0] TC_OPEN_ALL = 8'h47;
	localparam logic [CODE_W-1:0] TC_PROGRAM = 8'h48;

	// Key codes on the keypad strobe.
	localparam logic [3:0] KEY_BACK = 4'ha;

	// Message codes for the display.
	typedef enum logic [2:0]
	{
		MSG_NONE = 3'b000,
		MSG_VERSION = 3'b001,
		MSG_DATA_SET = 3'b010,
		MSG_BIT_RATE = 3'b011,
		MSG_TEST_SEQ = 3'b100,
		MSG_WRONG_IF = 3'b101,
		MSG_NOT_AVAIL = 3'b110,
		MSG_FAILED = 3'b111
	} tcx_msg_e;

	// Timing: flash on 250 ms and off 250 ms, two flashes; version shown 1 s.
	localparam int CLK_HZ = 20000000;
	localparam int FLASH_MS = 250;
	localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
	localparam int VERSION_MS = 1000;
	localparam int VERSION_CYCLES = CLK_HZ / 1000 * VERSION_MS;
	localparam int FLASH_COUNT = 4;

endpackage : tcx_pkg

/* File: tcx_allow.sv */
// Allowable-crosspoint lookup of the cross-connect matrix.
// Assumes lead and function indices as laid out in the package.
`timescale 1ns/100ps
module tcx_allow
(
	input wire logic [tcx_pkg::LEAD_W-1:0] lead,
	input wire logic [tcx_pkg::FUNC_W-1:0] func,
	output logic allowed
);
	import tcx_pkg::*;

	// ==========================================================
	// Per-lead function masks; bit n is function index n.
	logic [NUM_FUNCS-1:0] row;

	always_comb
	begin
		unique case (lead)
			5'h00: row = 15'h4007;
			5'h01: row = 15'h003e;
			5'h02, 5'h03: row = 15'h2002;
			5'h04: row = 15'h0f06;
			5'h05, 5'h06, 5'h07, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h11: row = 15'h003e;
			5'h08: row = 15'h4fff;
			5'h0b: row = 15'h4f07;
			5'h0e, 5'h0f: row = 15'h0f06;
			5'h10, 5'h12: row = 15'h0ffe;
			5'h13: row = 15'h0002;
			5'h14: row = 15'h0f02;
			5'h15, 5'h16, 5'h1a: row = 15'h3002;
			5'h17: row = 15'h403f;
			5'h18, 5'h19: row = 15'h4003;
			default: row = 15'h0000;
		endcase
	end

	assign allowed = (func < 4'hf) && row[func];

endmodule : tcx_allow

/* File: tcx_preset.sv */
// Preset connection table: test code and data set class to crosspoint set.
// Assumes the caller has already decided that presets are in force.
`timescale 1ns/100ps
module tcx_preset
(
	input wire logic [tcx_pkg::CODE_W-1:0] code,
	input wire tcx_pkg::tcx_class_e ds_class,
	output tcx_pkg::tcx_net_t net,
	output logic listed
);
	import tcx_pkg::*;

	function automatic tcx_net_t xp(input logic [LEAD_W-1:0] l, input logic [FUNC_W-1:0] f);
		tcx_net_t v;
		v = '0;
		v[l*NUM_FUNCS+f] = 1'b1;
		return v;
	endfunction : xp

	// ==========================================================
	// Shared groups.
	wire tcx_net_t rs_dtr = xp(L_RS, F_SW1) | xp(L_DTR, F_SW2);
	wire tcx_net_t sync_clk = xp(L_SCR, F_CLK_R) | xp(L_SCT, F_CLK_T);
	wire tcx_net_t async_clk = xp(L_ASYNC_CLK, F_CLK_R) | xp(L_DEV_TCLK, F_CLK_T);
	wire tcx_net_t csu_clk = xp(L_CSU_CLK, F_CLK_R) | xp(L_DEV_TCLK, F_CLK_T);
	wire tcx_net_t ctr_base = rs_dtr | xp(L_RS, F_CTR_A);
	wire is_csu = (ds_class == DS_CSU);
	wire is_async = (ds_class == DS_ASYNC);

	always_comb
	begin
		net = '0;
		listed = 1'b1;
		unique case (code)
			8'h30: net = ctr_base | xp(L_CS, F_CTR_B);
			8'h31: net = ctr_base | xp(L_RLSD, F_CTR_B);
			8'h32: net = ctr_base | xp(L_SQD, F_CTR_B);
			8'h36: net = xp(L_RS, F_SW1);
			8'h37: net = xp(L_DTR, F_SW2);
			8'h39: net = rs_dtr | xp(L_SRS15, F_SW3) | xp(L_SRLSD, F_IND1);
			8'h40: net = rs_dtr | xp(L_RI, F_IND1) | xp(L_DSR, F_IND2);
			8'h50: net = xp(L_RD, F_RECV_BUF) | xp(L_DTR, F_SW2) | xp(L_RLSD, F_IND2)
				| xp(L_ASYNC_CLK, F_CLK_R);
			8'h51, 8'h52, 8'h58:
			begin
				if (is_csu)
					net = xp(L_SD, F_SEND_BUF) | csu_clk;
				else
					net = rs_dtr | xp(L_CS, F_IND1) | xp(L_SD, F_SEND_BUF)
						| (is_async ? xp(L_SRS15, F_SW3) | xp(L_ASYNC_CLK, F_CLK_R)
						: sync_clk);
				if (code == 8'h58)
					net = net | xp(L_RLSD, F_IND2);
			end
			8'h53, 8'h54: net = rs_dtr | xp(L_RD, F_RECV_BUF) | xp(L_SD, F_SEND_PRBS)
				| (is_async ? xp(L_SRS15, F_SW3) | async_clk : sync_clk);
			8'h55: net = xp(L_RD, F_RECV_BUF) | xp(L_SD, F_SEND_PRBS) | csu_clk;
			8'h57, 8'h79: net = rs_dtr | xp(L_SRS15, F_SW3) | xp(L_RD, F_RECV_BUF)
				| xp(L_SD, F_SEND_BUF) | async_clk;
			8'h62, 8'h63, 8'h64, 8'h65: net = xp(L_RD, F_RECV_BUF) | xp(L_SD, F_SEND_BUF)
				| csu_clk;
			8'h67, 8'h68, 8'h70, 8'h71: net = rs_dtr | xp(L_RD, F_RECV_BUF)
				| xp(L_SD, F_SEND_BUF) | sync_clk | xp(L_RLSD, F_IND1);
			8'h78: net = xp(L_RD, F_RECV_BUF) | xp(L_SRS9, F_IND1) | xp(L_SRS9, F_SW1);
			default: listed = 1'b0;
		endcase
	end

endmodule : tcx_preset

/* File: tcx_ctrl.sv */
// Top of the cross-connect controller: entry sequence, network state and key interrupts.
// Assumes keypad, module id and self-test results arrive from pins; keys are debounced.
`timescale 1ns/100ps
module tcx_ctrl
#(
	parameter int FLASH_CYC = tcx_pkg::FLASH_CYCLES,
	parameter int VERSION_CYC = tcx_pkg::VERSION_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reset_key,
	input wire logic sequence_cancel_key,
	input wire logic go_key,
	input wire logic digit_strobe,
	input wire logic [3:0] digit_value,
	input wire logic [1:0] module_class,
	input wire logic selftest_done,
	input wire logic selftest_pass,
	input wire logic test_strobe,
	input wire logic [tcx_pkg::CODE_W-1:0] test_code,
	input wire logic prog_strobe,
	input wire logic [tcx_pkg::LEAD_W-1:0] prog_lead,
	input wire logic [tcx_pkg::FUNC_W-1:0] prog_func,
	output tcx_pkg::tcx_net_t crosspoints,
	output logic prog_refused,
	output tcx_pkg::tcx_msg_e message,
	output logic message_flash,
	output logic selftest_start,
	output logic [tcx_pkg::CODE_W-1:0] data_set_code,
	output logic [tcx_pkg::CODE_W-1:0] bit_rate_code,
	output logic [2:0] key_irq
);
	import tcx_pkg::*;

	// ==========================================================
	// Pin synchronisers and edge detection.
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	logic [6:0] sync3_reg;
	// Digit value and module class take the same two stages, so they line up with the strobe edge.
	logic [3:0] dval1_reg;
	logic [3:0] dval2_reg;
	logic [1:0] cls1_reg;
	logic [1:0] cls2_reg;
	wire [6:0] raw_pins = {digit_strobe, sequence_cancel_key, go_key, reset_key, selftest_done, selftest_pass,
		1'b0};

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			dval1_reg <= 4'h0;
			dval2_reg <= 4'h0;
			cls1_reg <= 2'h0;
			cls2_reg <= 2'h0;
		end
		else
		begin
			sync1_reg <= raw_pins;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			dval1_reg <= digit_value;
			dval2_reg <= dval1_reg;
			cls1_reg <= module_class;
			cls2_reg <= cls1_reg;
		end
	end

	wire [6:0] rise = sync2_reg & ~sync3_reg;
	wire digit_ev = rise[6];
	wire cancel_ev = rise[5];
	wire go_ev = rise[4];
	wire reset_ev = rise[3];
	wire st_done_ev = rise[2];
	wire st_pass = sync2_reg[1];

	// Interrupt pulses for reset, cancel and GO keys rather than level polling.
	assign key_irq = {reset_ev, cancel_ev, go_ev};

	// ==========================================================
	// Entry state machine.
	typedef enum logic [2:0]
	{
		ST_VERSION = 3'b000,
		ST_SELFTEST = 3'b001,
		ST_DATA_SET = 3'b010,
		ST_BIT_RATE = 3'b011,
		ST_TEST_SEQ = 3'b100,
		ST_FAILED = 3'b101
	} tcx_state_e;

	tcx_state_e state_reg;
	tcx_state_e state_next;
	logic [7:0] entry_reg;
	logic [7:0] entry_next;
	logic [1:0] ndig_reg;
	logic [1:0] ndig_next;
	logic [CODE_W-1:0] ds_reg;
	logic [CODE_W-1:0] ds_next;
	logic [CODE_W-1:0] br_reg;
	logic [CODE_W-1:0] br_next;
	logic [31:0] timer_reg;
	logic [31:0] timer_next;
	logic [2:0] flash_reg;
	logic [2:0] flash_next;
	tcx_msg_e flash_msg_reg;
	tcx_msg_e flash_msg_next;

	// Data set code classification; unlisted codes are not available.
	wire [7:0] entered = entry_reg;
	wire ds_sync = (entered >= 8'h20 && entered <= 8'h25) || entered == 8'h80 || entered == 8'h85;
	wire ds_async = (entered >= 8'h60 && entered <= 8'h62) || entered == 8'h36 || entered == 8'h66;
	wire ds_csu = entered == 8'h70 || entered == 8'h71 || entered == 8'h75 || entered == 8'h99;
	wire ds_known = ds_sync | ds_async | ds_csu;
	wire [1:0] ds_cls = ds_csu ? DS_CSU : (ds_async ? DS_ASYNC : DS_SYNC);
	wire if_ok = (cls2_reg == ds_cls);
	wire br_known = (entered >= 8'h01 && entered <= 8'h16);
	wire entry_full = (ndig_reg == 2'd2);
	wire back_ev = digit_ev && dval2_reg == KEY_BACK;
	wire num_ev = digit_ev && dval2_reg < KEY_BACK;
	wire flashing = (flash_reg != 3'd0);

	always_comb
	begin
		state_next = state_reg;
		entry_next = entry_reg;
		ndig_next = ndig_reg;
		ds_next = ds_reg;
		br_next = br_reg;
		timer_next = (timer_reg != 0) ? timer_reg - 1 : 32'd0;
		flash_next = flash_reg;
		flash_msg_next = flash_msg_reg;
		if (flashing && timer_reg == 0)
		begin
			flash_next = flash_reg - 3'd1;
			timer_next = 32'(FLASH_CYC);
		end
		unique case (state_reg)
			ST_VERSION: if (timer_reg == 0) state_next = ST_SELFTEST;
			ST_SELFTEST:
			begin
				if (st_done_ev)
					state_next = st_pass ? ST_DATA_SET : ST_FAILED;
			end
			ST_DATA_SET, ST_BIT_RATE:
			begin
				if (num_ev && !entry_full && !flashing)
				begin
					entry_next = {entry_reg[3:0], dval2_reg};
					ndig_next = ndig_reg + 2'd1;
				end
				else if (back_ev && ndig_reg != 2'd0)
				begin
					entry_next = {4'h0, entry_reg[7:4]};
					ndig_next = ndig_reg - 2'd1;
				end
				else if (go_ev && entry_full)
				begin
					ndig_next = 2'd0;
					entry_next = 8'h00;
					flash_next = 3'(FLASH_COUNT);
					timer_next = 32'(FLASH_CYC);
					if (state_reg == ST_DATA_SET && !ds_known || state_reg == ST_BIT_RATE && !br_known)
						flash_msg_next = MSG_NOT_AVAIL;
					else if (state_reg == ST_DATA_SET && !if_ok)
						flash_msg_next = MSG_WRONG_IF;
					else
					begin
						flash_next = 3'd0;
						if (state_reg == ST_DATA_SET)
						begin
							ds_next = entered;
							state_next = ST_BIT_RATE;
						end
						else
						begin
							br_next = entered;
							state_next = ST_TEST_SEQ;
						end
					end
				end
			end
			ST_TEST_SEQ: state_next = ST_TEST_SEQ;
			ST_FAILED: state_next = ST_FAILED;
			default: state_next = ST_FAILED;
		endcase
		if (reset_ev)
		begin
			state_next = ST_VERSION;
			timer_next = 32'(VERSION_CYC);
			ndig_next = 2'd0;
			entry_next = 8'h00;
			flash_next = 3'd0;
			ds_next = 8'h00;
			br_next = 8'h00;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_VERSION;
			entry_reg <= 8'h00;
			ndig_reg <= 2'd0;
			ds_reg <= 8'h00;
			br_reg <= 8'h00;
			timer_reg <= 32'(VERSION_CYC);
			flash_reg <= 3'd0;
			flash_msg_reg <= MSG_NONE;
		end
		else
		begin
			state_reg <= state_next;
			entry_reg <= entry_next;
			ndig_reg <= ndig_next;
			ds_reg <= ds_next;
			br_reg <= br_next;
			timer_reg <= timer_next;
			flash_reg <= flash_next;
			flash_msg_reg <= flash_msg_next;
		end
	end

	assign selftest_start = (state_reg == ST_VERSION) && (timer_reg == 0);
	assign data_set_code = ds_reg;
	assign bit_rate_code = br_reg;
	assign message_flash = flashing && flash_reg[0];
	assign message = flashing ? flash_msg_reg
		: state_reg == ST_VERSION ? MSG_VERSION
		: state_reg == ST_SELFTEST ? MSG_VERSION
		: state_reg == ST_DATA_SET ? MSG_DATA_SET
		: state_reg == ST_BIT_RATE ? MSG_BIT_RATE
		: state_reg == ST_TEST_SEQ ? MSG_TEST_SEQ : MSG_FAILED;

	// ==========================================================
	// Cross-connect network.
	tcx_net_t net_reg;
	logic prog_mode_reg;
	logic refused_reg;
	tcx_net_t preset_net;
	logic preset_listed;
	logic prog_ok;
	tcx_class_e cls;

	assign cls = ds_reg >= 8'h70 && ds_reg <= 8'h99 && ds_reg != 8'h80 && ds_reg != 8'h85 ? DS_CSU
		: (ds_reg >= 8'h60 || ds_reg == 8'h36) && ds_reg != 8'h80 && ds_reg != 8'h85 ? DS_ASYNC : DS_SYNC;

	tcx_preset u_preset
	(
		.code(test_code),
		.ds_class(cls),
		.net(preset_net),
		.listed(preset_listed)
	);

	tcx_allow u_allow
	(
		.lead(prog_lead),
		.func(prog_func),
		.allowed(prog_ok)
	);

	wire in_tests = (state_reg == ST_TEST_SEQ);
	wire tc_open = in_tests && test_strobe && test_code == TC_OPEN_ALL;
	wire tc_prog = in_tests && test_strobe && test_code == TC_PROGRAM;
	wire tc_preset = in_tests && test_strobe && preset_listed && !prog_mode_reg;
	wire prog_take = in_tests && prog_strobe && prog_mode_reg && prog_ok;
	wire [8:0] prog_bit = 9'(prog_lead * NUM_FUNCS + prog_func);

	always_ff @(posedge clk)
	begin
		if (!rst_n || reset_ev)
		begin
			net_reg <= '0;
			prog_mode_reg <= 1'b0;
			refused_reg <= 1'b0;
		end
		else
		begin
			refused_reg <= in_tests && prog_strobe && !(prog_mode_reg && prog_ok);
			if (tc_open)
			begin
				net_reg <= '0;
				prog_mode_reg <= 1'b0;
			end
			else if (tc_prog)
				prog_mode_reg <= 1'b1;
			else if (tc_preset)
				net_reg <= preset_net;
			else if (prog_take)
				net_reg[prog_bit] <= 1'b1;
		end
	end

	assign crosspoints = net_reg;
	assign prog_refused = refused_reg;

	// ==========================================================
	// Checks.
	a_preset_replace: assert property (@(posedge clk) disable iff (!rst_n)
		tc_preset && !reset_ev |=> crosspoints == $past(preset_net)) else $error("preset not loaded");
	a_unlisted_keep: assert property (@(posedge clk) disable iff (!rst_n)
		in_tests && test_strobe && !preset_listed && !tc_open && !tc_prog && !prog_strobe && !reset_ev
		|=> $stable(crosspoints)) else $error("unlisted code changed network");
	a_refuse_keep: assert property (@(posedge clk) disable iff (!rst_n)
		in_tests && prog_strobe && !prog_ok && !test_strobe && !reset_ev |=> $stable(crosspoints) && prog_refused)
		else $error("disallowed crosspoint closed");
	a_prog_close: assert property (@(posedge clk) disable iff (!rst_n)
		prog_take && !test_strobe && !reset_ev |=> crosspoints[$past(prog_bit)])
		else $error("requested crosspoint not closed");
	a_prog_override: assert property (@(posedge clk) disable iff (!rst_n)
		prog_mode_reg && test_strobe && test_code != TC_OPEN_ALL && !prog_strobe && !reset_ev
		|=> $stable(crosspoints)) else $error("preset overrode program");
	a_key_irq: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(go_key) |-> ##2 key_irq[0]) else $error("go interrupt missing");
	a_prompt_pass: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == ST_DATA_SET |-> $past(state_reg) != ST_VERSION) else $error("prompt before self-test");
	sequence s_bad_go;
		state_reg == ST_DATA_SET && go_ev && entry_full && !ds_known && !reset_ev;
	endsequence
	sequence s_not_avail_shown;
		state_reg == ST_DATA_SET && message == MSG_NOT_AVAIL;
	endsequence
	a_bad_code: assert property (@(posedge clk) disable iff (!rst_n)
		s_bad_go |=> s_not_avail_shown) else $error("bad code accepted");
	a_ctr_input_a: assert property (@(posedge clk) disable iff (!rst_n)
		tc_preset && test_code == 8'h30 && !reset_ev |=> crosspoints[L_RS*NUM_FUNCS+F_CTR_A])
		else $error("counter input a not closed");

endmodule : tcx_ctrl

/* File: tcx_far_end.sv */
// Far-end model: the fitted interface module and the self-test hardware.
// Assumes the controller pulses selftest_start once for each reset sequence.
`timescale 1ns/100ps
module tcx_far_end
#(
	parameter int DELAY = 5
)
(
	input wire logic clk,
	input wire logic fit_pass,
	input wire logic [1:0] fit_class,
	input wire logic selftest_start,
	output logic selftest_done,
	output logic selftest_pass,
	output logic [1:0] module_class
);
	// ==========================================================
	// Self-test answer and fitted module
	int cnt = 0;
	int hold = 0;
	logic win;
	initial selftest_done = 1'b0;
	assign win = (cnt >= 1 && cnt <= 2) || selftest_done;
	// Outside the result window the pass line shows the inverse, so a stale level reads as the opposite result.
	assign selftest_pass = win ? fit_pass : ~fit_pass;
	assign module_class = fit_class;
	always @(posedge clk)
	begin
		if (selftest_start)
			cnt <= DELAY;
		else if (cnt > 0)
			cnt <= cnt - 1;
		selftest_done <= (cnt == 1) || (selftest_done && hold < 3);
		hold <= selftest_done ? hold + 1 : 0;
	end
endmodule : tcx_far_end

/* File: test_code_crossconnect_controller_tb_top.sv */
// Bench for the test code cross-connect controller: key entry, presets and programmed crosspoints.
// Assumes short flash and version timers and that data set code 20 names a synchronous set.
`timescale 1ns/100ps
module test_code_crossconnect_controller_tb_top;
	import tcx_pkg::*;
	// ==========================================================
	// Pins, design and far end
	localparam int LIMIT = 20000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic reset_key = 1'b0;
	logic sequence_cancel_key = 1'b0;
	logic go_key = 1'b0;
	logic digit_strobe = 1'b0;
	logic [3:0] digit_value = 4'h0;
	logic test_strobe = 1'b0;
	logic [CODE_W-1:0] test_code = 8'h00;
	logic prog_strobe = 1'b0;
	logic [LEAD_W-1:0] prog_lead = 5'h00;
	logic [FUNC_W-1:0] prog_func = 4'h0;
	logic fit_pass = 1'b0;
	logic [1:0] fit_class = DS_SYNC;
	logic [1:0] module_class;
	logic selftest_done, selftest_pass, selftest_start, prog_refused, message_flash;
	tcx_net_t crosspoints;
	tcx_msg_e message;
	logic [CODE_W-1:0] data_set_code, bit_rate_code;
	logic [2:0] key_irq;
	logic flash_q = 1'b0;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	int flash_rises = 0;
	int refusals = 0;
	int r0;
	int msg_cnt [8];
	int irq_cnt [3];
	int nkey [4];
	tcx_net_t e;
	logic [7:0] ctr_code [3] = '{8'h30, 8'h31, 8'h32};
	logic [4:0] ctr_b [3] = '{L_CS, L_RLSD, L_SQD};

	tcx_ctrl #(.FLASH_CYC(4), .VERSION_CYC(8)) dut
	(
		.clk(clk), .rst_n(rst_n), .reset_key(reset_key), .sequence_cancel_key(sequence_cancel_key),
		.go_key(go_key), .digit_strobe(digit_strobe), .digit_value(digit_value),
		.module_class(module_class), .selftest_done(selftest_done), .selftest_pass(selftest_pass),
		.test_strobe(test_strobe), .test_code(test_code), .prog_strobe(prog_strobe),
		.prog_lead(prog_lead), .prog_func(prog_func), .crosspoints(crosspoints),
		.prog_refused(prog_refused), .message(message), .message_flash(message_flash),
		.selftest_start(selftest_start), .data_set_code(data_set_code),
		.bit_rate_code(bit_rate_code), .key_irq(key_irq)
	);
	tcx_far_end far
	(
		.clk(clk), .fit_pass(fit_pass), .fit_class(fit_class), .selftest_start(selftest_start),
		.selftest_done(selftest_done), .selftest_pass(selftest_pass), .module_class(module_class)
	);

	initial
	begin
		forever #25 clk = ~clk;
	end

	// ==========================================================
	// Monitor and timeout
	always @(posedge clk)
	begin
		cycles++;
		flash_q <= message_flash;
		if (message_flash === 1'b1 && flash_q === 1'b0)
			flash_rises++;
		if (prog_refused === 1'b1)
			refusals++;
		for (int i = 0; i < 3; i++)
			if (key_irq[i] === 1'b1)
				irq_cnt[i]++;
		msg_cnt[message]++;
		if (cycles == LIMIT)
		begin
			mismatches++;
			final_report();
		end
	end

	// ==========================================================
	// Tasks
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	task automatic chk(input tcx_net_t got, input tcx_net_t exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic tcx_net_t pt(input logic [LEAD_W-1:0] l, input logic [FUNC_W-1:0] f);
		tcx_net_t n;
		n = '0;
		n[l * NUM_FUNCS + f] = 1'b1;
		return n;
	endfunction : pt

	// Paired data and clock columns may gain partner crosspoints, so only listed ones are demanded there.
	task automatic net_chk(input tcx_net_t exp);
		tcx_net_t pm;
		pm = '0;
		for (int l = 0; l < NUM_LEADS; l++)
			pm = pm | pt(l, F_SEND_PRBS) | pt(l, F_RECV_BUF) | pt(l, F_CLK_T) | pt(l, F_CLK_R) | pt(l, F_SEND_BUF);
		chk(crosspoints & exp, exp);
		chk(crosspoints & ~pm, exp & ~pm);
	endtask : net_chk

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask : settle

	// Key kinds: 0 digit, 1 go, 2 cancel, 3 reset; pins are slow levels passing a synchroniser.
	task automatic pin(input int k, input logic [3:0] v);
		nkey[k]++;
		@(posedge clk);
		if (k == 0)
			digit_value <= v;
		case (k)
			0: digit_strobe <= 1'b1;
			1: go_key <= 1'b1;
			2: sequence_cancel_key <= 1'b1;
			default: reset_key <= 1'b1;
		endcase
		settle(5);
		digit_strobe <= 1'b0;
		go_key <= 1'b0;
		sequence_cancel_key <= 1'b0;
		reset_key <= 1'b0;
		settle(6);
	endtask : pin

	task automatic enter(input logic [3:0] a, input logic [3:0] b);
		pin(0, KEY_BACK);
		pin(0, KEY_BACK);
		pin(0, a);
		pin(0, b);
	endtask : enter

	task automatic attempt(input logic [3:0] a, input logic [3:0] b, input tcx_msg_e m);
		int m0;
		int f0;
		m0 = msg_cnt[m];
		f0 = flash_rises;
		enter(a, b);
		pin(1, 4'h0);
		settle(60);
		chk(msg_cnt[m] > m0, 1);
		chk(flash_rises - f0, 2);
	endtask : attempt

	task automatic tcode(input logic [7:0] c);
		@(posedge clk);
		test_code <= c;
		test_strobe <= 1'b1;
		@(posedge clk);
		test_strobe <= 1'b0;
		settle(3);
	endtask : tcode

	task automatic prog(input logic [LEAD_W-1:0] l, input logic [FUNC_W-1:0] f);
		@(posedge clk);
		prog_lead <= l;
		prog_func <= f;
		prog_strobe <= 1'b1;
	endtask : prog

	task automatic idle();
		@(posedge clk);
		prog_strobe <= 1'b0;
		settle(3);
	endtask : idle

	// ==========================================================
	// Main sequence
	initial
	begin
		settle(16);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk(message, MSG_VERSION);
		chk(crosspoints, '0);
		settle(40);
		chk(message, MSG_FAILED);
		fit_pass <= 1'b1;
		pin(3, 4'h0);
		settle(40);
		chk(message, MSG_DATA_SET);
		fit_class <= DS_NONE;
		attempt(4'h2, 4'h0, MSG_WRONG_IF);
		chk(message, MSG_DATA_SET);
		fit_class <= DS_SYNC;
		attempt(4'h0, 4'h0, MSG_NOT_AVAIL);
		chk(message, MSG_DATA_SET);
		pin(0, 4'h2);
		pin(0, 4'h5);
		enter(4'h2, 4'h0);
		pin(1, 4'h0);
		settle(10);
		chk(data_set_code, 8'h20);
		chk(message, MSG_BIT_RATE);
		attempt(4'h1, 4'h7, MSG_NOT_AVAIL);
		chk(message, MSG_BIT_RATE);
		enter(4'h0, 4'h1);
		pin(1, 4'h0);
		settle(10);
		chk(bit_rate_code, 8'h01);
		chk(message, MSG_TEST_SEQ);
		for (int i = 0; i < 3; i++)
		begin
			tcode(ctr_code[i]);
			e = pt(L_RS, F_CTR_A) | pt(L_RS, F_SW1) | pt(L_DTR, F_SW2) | pt(ctr_b[i], F_CTR_B);
			net_chk(e);
		end
		tcode(8'h41);
		net_chk(e);
		tcode(8'h39);
		net_chk(pt(L_RS, F_SW1) | pt(L_DTR, F_SW2) | pt(L_SRS15, F_SW3) | pt(L_SRLSD, F_IND1));
		tcode(8'h40);
		net_chk(pt(L_RS, F_SW1) | pt(L_DTR, F_SW2) | pt(L_RI, F_IND1) | pt(L_DSR, F_IND2));
		tcode(8'h51);
		net_chk(pt(L_RS, F_SW1) | pt(L_CS, F_IND1) | pt(L_DTR, F_SW2) | pt(L_SD, F_SEND_BUF) | pt(L_SCR, F_CLK_R));
		tcode(8'h53);
		e = pt(L_RS, F_SW1) | pt(L_DTR, F_SW2) | pt(L_RD, F_RECV_BUF) | pt(L_SD, F_SEND_PRBS);
		e = e | pt(L_SCT, F_CLK_T) | pt(L_SCR, F_CLK_R);
		net_chk(e);
		r0 = refusals;
		prog(L_RS, F_CTR_A);
		idle();
		chk(refusals - r0, 1);
		net_chk(e);
		tcode(TC_OPEN_ALL);
		chk(crosspoints, '0);
		tcode(TC_PROGRAM);
		r0 = refusals;
		prog(L_RS, F_SW1);
		prog(L_DTR, F_SW2);
		prog(L_SD, F_IND1);
		idle();
		chk(refusals - r0, 1);
		e = pt(L_RS, F_SW1) | pt(L_DTR, F_SW2);
		chk(crosspoints, e);
		tcode(8'h30);
		chk(crosspoints, e);
		pin(2, 4'h0);
		pin(3, 4'h0);
		chk(crosspoints, '0);
		chk(data_set_code, 8'h00);
		chk(irq_cnt[0], nkey[1]);
		chk(irq_cnt[1], nkey[2]);
		chk(irq_cnt[2], nkey[3]);
		settle(40);
		fit_class <= DS_CSU;
		enter(4'h7, 4'h0);
		pin(1, 4'h0);
		enter(4'h0, 4'h1);
		pin(1, 4'h0);
		settle(10);
		chk(message, MSG_TEST_SEQ);
		tcode(8'h55);
		net_chk(pt(L_RD, F_RECV_BUF) | pt(L_SD, F_SEND_PRBS) | pt(L_CSU_CLK, F_CLK_R));
		tcode(8'h62);
		net_chk(pt(L_RD, F_RECV_BUF) | pt(L_SD, F_SEND_BUF) | pt(L_CSU_CLK, F_CLK_R));
		chk(crosspoints & pt(L_SD, F_SEND_PRBS), '0);
		tcode(8'h50);
		e = pt(L_RD, F_RECV_BUF) | pt(L_DTR, F_SW2) | pt(L_RLSD, F_IND2);
		net_chk(e | pt(L_ASYNC_CLK, F_CLK_R));
		final_report();
	end
endmodule : test_code_crossconnect_controller_tb_top
